// >>> hdl/acq_pkg.sv
// shared constants, register map and range codes for the sample acquisition block
package acq_pkg;
    localparam int ADDR_W    = 16;
    localparam int DATA_W    = 32;
    localparam int SAMPLE_W  = 16;
    localparam int NUM_CHAN  = 8;
    localparam int NUM_RANGE = 7;
    localparam int NUM_COEF  = NUM_CHAN * NUM_RANGE;
    localparam int COEF_IDX_W = 6;
    localparam int CHAN_W    = 3;

    // register offsets (byte addresses)
    localparam logic [15:0] IRQ_ENABLE_ADDR  = 16'h2008;
    localparam logic [15:0] ACQ_CONTROL_ADDR = 16'h7008;
    localparam logic [15:0] RANGE_CHAN_ADDR  = 16'h700c;
    localparam logic [15:0] CONV_TIMER_ADDR  = 16'h7014;
    localparam logic [15:0] FIFO_THRESH_ADDR = 16'h7018;
    localparam logic [15:0] CONV_START_ADDR  = 16'h701c;
    localparam logic [15:0] FIFO_DATA_ADDR   = 16'h7020;
    localparam logic [15:0] FIFO_COUNT_ADDR  = 16'h7024;
    localparam logic [15:0] COEF_BASE_ADDR   = 16'h7100;
    localparam logic [15:0] COEF_SPAN        = 16'h01c0;

    // field positions
    localparam int IRQ_THRESH_BIT = 9;
    localparam int CTRL_CONT_BIT  = 1;
    localparam int CTRL_W         = 4;
    localparam int START_BIT      = 0;
    localparam int RANGE_FIELD_W  = 4;
    localparam int TIMER_W        = 16;

    // reset values
    localparam logic [31:0] IRQ_ENABLE_RST  = 32'h0000_0000;
    localparam logic [3:0]  ACQ_CONTROL_RST = 4'h0;
    localparam logic [31:0] RANGE_CHAN_RST  = 32'h0000_0000;
    localparam logic [15:0] CONV_TIMER_RST  = 16'h0000;
    localparam logic [31:0] FIFO_THRESH_RST = 32'h0000_0000;
    localparam logic [31:0] OFFSET_RST      = 32'h0000_0000;
    localparam logic [31:0] GAIN_UNITY      = 32'h0001_0000;

    // correction arithmetic
    localparam int          GAIN_FRAC     = 16;
    localparam logic [15:0] UNIPOLAR_FLIP = 16'h8000;
    localparam logic [15:0] SAT_POS       = 16'h7fff;
    localparam logic [15:0] SAT_NEG       = 16'h8000;

    // sample fifo
    localparam int FIFO_DEPTH = 1024;
    localparam int FIFO_AW    = 10;
    localparam int FIFO_CW    = 11;

    // conversion interval: (timer value + 1) ticks of 16 ns, paced from a 100 ns clock
    localparam int          TIMER_ACC_W   = 22;
    localparam logic [21:0] TIMER_TICK_NS = 22'h00_0010;
    localparam logic [21:0] CLK_PERIOD_NS = 22'h00_0064;

    // range codes held per channel; zero leaves the channel out of the scan
    typedef enum logic [3:0] {
        RANGE_OFF,
        RANGE_U5P12,
        RANGE_B5P0,
        RANGE_B5P12,
        RANGE_U10P0,
        RANGE_U10P24,
        RANGE_B10P0,
        RANGE_B10P24
    } range_code_t;

    typedef enum logic [1:0] {
        SEQ_IDLE,
        SEQ_CONVERT,
        SEQ_SCALE,
        SEQ_STORE
    } seq_state_t;

    // unipolar spans get their top bit flipped before correction
    function automatic logic is_unipolar(input logic [3:0] rc);
        is_unipolar = (rc == RANGE_U5P12) || (rc == RANGE_U10P0) || (rc == RANGE_U10P24);
    endfunction
endpackage

// >>> hdl/adc_sample_correction_acquisition.sv
// converter sequencing, per-channel offset/gain correction and sample fifo
//
// Overview of operation
// - corrected sample is (raw plus offset) times gain, divided by 2^16
// - correction is done in hardware; only corrected samples enter the fifo
// - gain is fixed point scaled by 2^16; 65536 means unity
// - separate offset and gain per channel and per range, picked per sample
// - spans 5.12, 10, 10.24, 20 and 20.48 volts, unipolar and bipolar
// - writing 0200h at 2008h enables the fifo threshold interrupt
// - writing 0002h at 7008h selects continuous conversion mode
// - writing zero to the control register stops further conversions
// - writing 0007h at 700ch selects a range and enables channel 0
// - timer at 7014h sets conversion spacing; 53h gives 1.344 us
// - threshold at 7018h; interrupt once that many samples are stored
// - writing 0001h at 701ch starts conversions, repeating in continuous mode
// - stopping keeps channel enable, timer and threshold settings
// - host loads correction registers; hardware uses them for later samples
`timescale 1ns/1ps
module adc_sample_correction_acquisition
    import acq_pkg::*;
(
    input  wire logic                clk_i,
    input  wire logic                rst_i,
    input  wire logic                reg_wr_i,
    input  wire logic                reg_rd_i,
    input  wire logic [ADDR_W-1:0]   reg_addr_i,
    input  wire logic [DATA_W-1:0]   reg_wdata_i,
    output logic [DATA_W-1:0]        reg_rdata_o,
    output logic                     irq_o,
    output logic                     conv_start_o,
    output logic [CHAN_W-1:0]        conv_chan_o,
    output logic [3:0]               conv_range_o,
    input  wire logic                raw_valid_i,
    input  wire logic [SAMPLE_W-1:0] raw_sample_i
);
    // software registers
    logic [31:0]            irq_en_ff;
    logic [CTRL_W-1:0]      ctrl_ff;
    logic [31:0]            range_en_ff;
    logic [TIMER_W-1:0]     timer_ff;
    logic [31:0]            thresh_ff;
    logic [31:0]            offset_mem_ff [NUM_COEF];
    logic [31:0]            gain_mem_ff   [NUM_COEF];

    // run control and pacing
    logic                   running_ff;
    logic                   pending_ff;
    logic [TIMER_ACC_W-1:0] acc_ff;
    logic [TIMER_ACC_W-1:0] acc_sum;
    logic [TIMER_ACC_W-1:0] target;
    logic                   tick;

    // sequencer and correction datapath
    seq_state_t             state_ff;
    logic [CHAN_W-1:0]      chan_ff;
    logic [3:0]             range_ff;
    logic signed [32:0]     sum_ff;
    logic signed [32:0]     gain_ff;
    logic [SAMPLE_W-1:0]    corr_ff;
    logic signed [65:0]     product;
    logic signed [49:0]     scaled;
    logic [SAMPLE_W-1:0]    nxt_corr;
    logic [SAMPLE_W-1:0]    raw_x;
    logic [CHAN_W-1:0]      nxt_chan;
    logic                   issue;
    logic [COEF_IDX_W-1:0]  sel_idx;

    // buffer and sample fifo
    logic                   buf_in_ready;
    logic                   buf_out_valid;
    logic [SAMPLE_W-1:0]    buf_out_data;
    logic                   buf_out_ready;
    logic [SAMPLE_W-1:0]    fifo_mem_ff [FIFO_DEPTH];
    logic [FIFO_AW-1:0]     fifo_wr_ff;
    logic [FIFO_AW-1:0]     fifo_rd_ff;
    logic [FIFO_CW-1:0]     fifo_cnt_ff;
    logic                   fifo_push;
    logic                   fifo_pop;

    // bus decode terms
    logic                   ctrl_wr;
    logic                   start_wr;
    logic                   stop_wr;
    logic [15:0]            coef_off;
    logic                   coef_hit;
    logic [COEF_IDX_W-1:0]  coef_pair;
    logic [31:0]            nxt_rdata;

    // a channel takes part when its range field holds a valid code
    function automatic logic chan_on(input logic [31:0] en, input logic [CHAN_W-1:0] c);
        logic [3:0] f;
        f = en[RANGE_FIELD_W*c +: RANGE_FIELD_W];
        chan_on = (f != RANGE_OFF) && (f <= RANGE_B10P24);
    endfunction

    // next enabled channel after the last one converted, wrapping round
    function automatic logic [CHAN_W-1:0] next_chan(input logic [31:0] en,
                                                    input logic [CHAN_W-1:0] last);
        logic [CHAN_W-1:0] c;
        logic              found;
        next_chan = last;
        found     = 1'b0;
        for (int i = 1; i <= NUM_CHAN; i++) begin
            c = last + CHAN_W'(i);
            if (!found && chan_on(en, c)) begin
                next_chan = c;
                found     = 1'b1;
            end
        end
    endfunction

    // coefficient slot of a channel and range code
    function automatic logic [COEF_IDX_W-1:0] coef_idx(input logic [CHAN_W-1:0] c,
                                                      input logic [3:0] rc);
        coef_idx = COEF_IDX_W'(c) * COEF_IDX_W'(NUM_RANGE) + COEF_IDX_W'(rc - 4'h1);
    endfunction

    // write strobes and coefficient window
    assign ctrl_wr   = reg_wr_i && (reg_addr_i == ACQ_CONTROL_ADDR);
    assign start_wr  = reg_wr_i && (reg_addr_i == CONV_START_ADDR) && reg_wdata_i[START_BIT];
    assign stop_wr   = ctrl_wr && !reg_wdata_i[CTRL_CONT_BIT];
    assign coef_off  = reg_addr_i - COEF_BASE_ADDR;
    assign coef_hit  = (reg_addr_i >= COEF_BASE_ADDR) && (coef_off < COEF_SPAN);
    assign coef_pair = coef_off[8:3];

    // configuration registers
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            irq_en_ff   <= IRQ_ENABLE_RST;
            ctrl_ff     <= ACQ_CONTROL_RST;
            range_en_ff <= RANGE_CHAN_RST;
            timer_ff    <= CONV_TIMER_RST;
            thresh_ff   <= FIFO_THRESH_RST;
        end else if (reg_wr_i) begin
            if (reg_addr_i == IRQ_ENABLE_ADDR) begin
                irq_en_ff <= reg_wdata_i;
            end else if (reg_addr_i == ACQ_CONTROL_ADDR) begin
                ctrl_ff <= reg_wdata_i[CTRL_W-1:0];
            end else if (reg_addr_i == RANGE_CHAN_ADDR) begin
                range_en_ff <= reg_wdata_i;
            end else if (reg_addr_i == CONV_TIMER_ADDR) begin
                timer_ff <= reg_wdata_i[TIMER_W-1:0];
            end else if (reg_addr_i == FIFO_THRESH_ADDR) begin
                thresh_ff <= reg_wdata_i;
            end
        end
    end

    // correction coefficients, offset word then gain word per slot
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            for (int i = 0; i < NUM_COEF; i++) begin
                offset_mem_ff[i] <= OFFSET_RST;
                gain_mem_ff[i]   <= GAIN_UNITY;
            end
        end else if (reg_wr_i && coef_hit) begin
            if (coef_off[2]) begin
                gain_mem_ff[coef_pair] <= reg_wdata_i;
            end else begin
                offset_mem_ff[coef_pair] <= reg_wdata_i;
            end
        end
    end

    // fractional pacing: interval is (timer + 1) * 16 ns on average
    assign target  = (TIMER_ACC_W'(timer_ff) + 22'h1) * TIMER_TICK_NS;
    assign acc_sum = acc_ff + CLK_PERIOD_NS;
    assign tick    = running_ff && !stop_wr && (acc_sum >= target);

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            acc_ff <= '0;
        end else if (!running_ff) begin
            acc_ff <= '0;
        end else if (tick) begin
            acc_ff <= acc_sum - target;
        end else begin
            acc_ff <= acc_sum;
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            running_ff <= 1'b0;
        // stop on control write without continuous bit
        end else if (stop_wr) begin
            running_ff <= 1'b0;
        end else if (start_wr && ctrl_ff[CTRL_CONT_BIT]) begin
            running_ff <= 1'b1;
        end
    end

    // pending conversion request; a new request wins over the issue clear
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            pending_ff <= 1'b0;
        end else if (tick || (start_wr && !ctrl_ff[CTRL_CONT_BIT])) begin
            pending_ff <= 1'b1;
        end else if (issue || stop_wr) begin
            pending_ff <= 1'b0;
        end
    end

    // sequencer selection and coefficient lookup
    assign nxt_chan = next_chan(range_en_ff, chan_ff);
    assign issue    = (state_ff == SEQ_IDLE) && pending_ff && chan_on(range_en_ff, nxt_chan);
    // pair chosen from channel and range of this sample
    assign sel_idx  = coef_idx(chan_ff, range_ff);
    // unipolar spans are offset binary; flip into two's complement
    assign raw_x    = is_unipolar(range_ff) ? (raw_sample_i ^ UNIPOLAR_FLIP) : raw_sample_i;

    // product of offset-adjusted sample and gain, divided by 2^16
    assign product = sum_ff * gain_ff;
    assign scaled  = product[65:GAIN_FRAC];

    // clamp to the signed sample range
    always_comb begin
        if (scaled > $signed({34'h0, SAT_POS})) begin
            nxt_corr = SAT_POS;
        end else if (scaled < -$signed({34'h0, SAT_NEG})) begin
            nxt_corr = SAT_NEG;
        end else begin
            nxt_corr = scaled[SAMPLE_W-1:0];
        end
    end

    // conversion sequencer: request, capture, scale, hand to buffer
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            state_ff <= SEQ_IDLE;
            chan_ff  <= '0;
            range_ff <= RANGE_OFF;
            sum_ff   <= '0;
            gain_ff  <= '0;
            corr_ff  <= '0;
        end else begin
            case (state_ff)
                SEQ_IDLE: begin
                    if (issue) begin
                        chan_ff  <= nxt_chan;
                        range_ff <= range_en_ff[RANGE_FIELD_W*nxt_chan +: RANGE_FIELD_W];
                        state_ff <= SEQ_CONVERT;
                    end
                end
                SEQ_CONVERT: begin
                    if (raw_valid_i) begin
                        // gain held as signed fixed point, 2^16 is unity
                        sum_ff   <= $signed({{17{raw_x[15]}}, raw_x})
                                  + $signed({offset_mem_ff[sel_idx][31],
                                             offset_mem_ff[sel_idx]});
                        gain_ff  <= $signed({gain_mem_ff[sel_idx][31], gain_mem_ff[sel_idx]});
                        state_ff <= SEQ_SCALE;
                    end
                end
                SEQ_SCALE: begin
                    corr_ff  <= nxt_corr;
                    state_ff <= SEQ_STORE;
                end
                SEQ_STORE: begin
                    if (buf_in_ready) begin
                        state_ff <= SEQ_IDLE;
                    end
                end
                default: begin
                    state_ff <= SEQ_IDLE;
                end
            endcase
        end
    end

    // converter request pins
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            conv_start_o <= 1'b0;
            conv_chan_o  <= '0;
            conv_range_o <= RANGE_OFF;
        end else begin
            conv_start_o <= issue;
            if (issue) begin
                conv_chan_o  <= nxt_chan;
                conv_range_o <= range_en_ff[RANGE_FIELD_W*nxt_chan +: RANGE_FIELD_W];
            end
        end
    end

    // corrected word goes to the buffer, never the raw count
    sample_skid_buffer u_buf (
        .clk_i       (clk_i),
        .rst_i       (rst_i),
        .in_valid_i  (state_ff == SEQ_STORE),
        .in_data_i   (corr_ff),
        .in_ready_o  (buf_in_ready),
        .out_valid_o (buf_out_valid),
        .out_data_o  (buf_out_data),
        .out_ready_i (buf_out_ready)
    );

    // fifo handshakes; a full fifo stalls the buffer and then the sequencer
    assign buf_out_ready = (fifo_cnt_ff != FIFO_CW'(FIFO_DEPTH));
    assign fifo_push     = buf_out_valid && buf_out_ready;
    assign fifo_pop      = reg_rd_i && (reg_addr_i == FIFO_DATA_ADDR) && (fifo_cnt_ff != '0);

    // fifo storage
    always_ff @(posedge clk_i) begin
        if (fifo_push) begin
            fifo_mem_ff[fifo_wr_ff] <= buf_out_data;
        end
    end

    // fifo pointers and count
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            fifo_wr_ff  <= '0;
            fifo_rd_ff  <= '0;
            fifo_cnt_ff <= '0;
        end else begin
            if (fifo_push) begin
                fifo_wr_ff <= fifo_wr_ff + FIFO_AW'(1);
            end
            if (fifo_pop) begin
                fifo_rd_ff <= fifo_rd_ff + FIFO_AW'(1);
            end
            if (fifo_push && !fifo_pop) begin
                fifo_cnt_ff <= fifo_cnt_ff + FIFO_CW'(1);
            end else if (fifo_pop && !fifo_push) begin
                fifo_cnt_ff <= fifo_cnt_ff - FIFO_CW'(1);
            end
        end
    end

    // interrupt level while count meets or exceeds threshold
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            irq_o <= 1'b0;
        end else begin
            irq_o <= irq_en_ff[IRQ_THRESH_BIT] && (32'(fifo_cnt_ff) >= thresh_ff);
        end
    end

    // read multiplexer; unmapped and write-only offsets read zero
    always_comb begin
        nxt_rdata = '0;
        if (reg_addr_i == IRQ_ENABLE_ADDR) begin
            nxt_rdata = irq_en_ff;
        end else if (reg_addr_i == ACQ_CONTROL_ADDR) begin
            nxt_rdata = {28'h0, ctrl_ff};
        end else if (reg_addr_i == RANGE_CHAN_ADDR) begin
            nxt_rdata = range_en_ff;
        end else if (reg_addr_i == CONV_TIMER_ADDR) begin
            nxt_rdata = {16'h0, timer_ff};
        end else if (reg_addr_i == FIFO_THRESH_ADDR) begin
            nxt_rdata = thresh_ff;
        end else if (reg_addr_i == FIFO_DATA_ADDR) begin
            nxt_rdata = (fifo_cnt_ff != '0) ? {16'h0, fifo_mem_ff[fifo_rd_ff]} : 32'h0;
        end else if (reg_addr_i == FIFO_COUNT_ADDR) begin
            nxt_rdata = 32'(fifo_cnt_ff);
        end else if (coef_hit) begin
            nxt_rdata = coef_off[2] ? gain_mem_ff[coef_pair] : offset_mem_ff[coef_pair];
        end
    end

    // read data register, loaded one cycle after the read strobe
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            reg_rdata_o <= '0;
        end else if (reg_rd_i) begin
            reg_rdata_o <= nxt_rdata;
        end else begin
            reg_rdata_o <= '0;
        end
    end
endmodule

// >>> hdl/sample_skid_buffer.sv
// two-entry valid/ready buffer between the correction stage and the sample fifo
`timescale 1ns/1ps
module sample_skid_buffer
    import acq_pkg::*;
(
    input  wire logic                clk_i,
    input  wire logic                rst_i,
    input  wire logic                in_valid_i,
    input  wire logic [SAMPLE_W-1:0] in_data_i,
    output logic                     in_ready_o,
    output logic                     out_valid_o,
    output logic [SAMPLE_W-1:0]      out_data_o,
    input  wire logic                out_ready_i
);
    logic [SAMPLE_W-1:0] slot_ff [2];
    logic                wr_ptr_ff;
    logic                rd_ptr_ff;
    logic [1:0]          count_ff;
    logic                push;
    logic                pop;

    // handshake terms from the fill count
    assign in_ready_o  = (count_ff != 2'h2);
    assign out_valid_o = (count_ff != 2'h0);
    assign out_data_o  = slot_ff[rd_ptr_ff];
    assign push        = in_valid_i && in_ready_o;
    assign pop         = out_valid_o && out_ready_i;

    // storage slots
    always_ff @(posedge clk_i) begin
        if (push) begin
            slot_ff[wr_ptr_ff] <= in_data_i;
        end
    end

    // pointers and fill count
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            wr_ptr_ff <= 1'b0;
            rd_ptr_ff <= 1'b0;
            count_ff  <= 2'h0;
        end else begin
            if (push) begin
                wr_ptr_ff <= ~wr_ptr_ff;
            end
            if (pop) begin
                rd_ptr_ff <= ~rd_ptr_ff;
            end
            if (push && !pop) begin
                count_ff <= count_ff + 2'h1;
            end else if (pop && !push) begin
                count_ff <= count_ff - 2'h1;
            end
        end
    end
endmodule

// >>> sim/acq_checker.sv
// port-level assertions for the sample acquisition block
`timescale 1ns/1ps
module acq_checker
    import acq_pkg::*;
(
    input wire logic              clk_i,
    input wire logic              rst_i,
    input wire logic              reg_wr_i,
    input wire logic              reg_rd_i,
    input wire logic [ADDR_W-1:0] reg_addr_i,
    input wire logic [DATA_W-1:0] reg_wdata_i,
    input wire logic [DATA_W-1:0] reg_rdata_o,
    input wire logic              irq_o,
    input wire logic              conv_start_o,
    input wire logic [CHAN_W-1:0] conv_chan_o,
    input wire logic [3:0]        conv_range_o
);
    logic [15:0] tmr_ff;
    logic [31:0] thr_ff;
    logic [31:0] rng_ff;
    logic        ien_ff;
    logic        run_ff;
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // shadow copies of what the host wrote
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            tmr_ff <= 16'h0000;
            thr_ff <= 32'h0000_0000;
            rng_ff <= 32'h0000_0000;
            ien_ff <= 1'b0;
            run_ff <= 1'b0;
        end else if (reg_wr_i) begin
            if (reg_addr_i == CONV_TIMER_ADDR) tmr_ff <= reg_wdata_i[15:0];
            if (reg_addr_i == FIFO_THRESH_ADDR) thr_ff <= reg_wdata_i;
            if (reg_addr_i == RANGE_CHAN_ADDR) rng_ff <= reg_wdata_i;
            if (reg_addr_i == IRQ_ENABLE_ADDR) ien_ff <= reg_wdata_i[IRQ_THRESH_BIT];
            if (reg_addr_i == ACQ_CONTROL_ADDR && !reg_wdata_i[CTRL_CONT_BIT]) run_ff <= 1'b0;
            if (reg_addr_i == CONV_START_ADDR && reg_wdata_i[START_BIT]) run_ff <= 1'b1;
        end
    end
    sequence quiet4;
        !conv_start_o [*4];
    endsequence
    start_gap_a: assert property (conv_start_o |=> quiet4)
        else $error("conversion request too long or repeated too soon");
    rdata_idle_a: assert property (!reg_rd_i |=> reg_rdata_o == 32'h0000_0000)
        else $error("read data not zero outside a read");
    irq_mask_a: assert property (!ien_ff |=> !irq_o)
        else $error("interrupt raised while disabled");
    stop_halts_a: assert property (conv_start_o |-> run_ff || $past(run_ff))
        else $error("conversion requested after stop");
    timer_hold_a: assert property (reg_rd_i && reg_addr_i == CONV_TIMER_ADDR
        |=> reg_rdata_o == {16'h0000, tmr_ff}) else $error("timer readback wrong");
    thresh_hold_a: assert property (reg_rd_i && reg_addr_i == FIFO_THRESH_ADDR
        |=> reg_rdata_o == thr_ff) else $error("threshold readback wrong");
    range_hold_a: assert property (reg_rd_i && reg_addr_i == RANGE_CHAN_ADDR
        |=> reg_rdata_o == rng_ff) else $error("range readback wrong");
    chan_range_a: assert property (conv_start_o
        |-> conv_range_o == rng_ff[{conv_chan_o, 2'b00} +: 4]) else $error("range tag wrong");
endmodule
bind adc_sample_correction_acquisition acq_checker chk_u (.clk_i, .rst_i, .reg_wr_i, .reg_rd_i,
    .reg_addr_i, .reg_wdata_i, .reg_rdata_o, .irq_o, .conv_start_o, .conv_chan_o, .conv_range_o);

// >>> sim/adc_converter_model.sv
// converter model: one sample per request after a short or long conversion
`timescale 1ns/1ps
module adc_converter_model
    import acq_pkg::*;
(
    input  wire logic                clk_i,
    input  wire logic                rst_i,
    input  wire logic                conv_start_i,
    input  wire logic                slow_i,
    input  wire logic [SAMPLE_W-1:0] level_i,
    output logic                     raw_valid_o,
    output logic [SAMPLE_W-1:0]      raw_sample_o
);
    logic [3:0] wait_ff;
    // count the conversion down; data lines toggle when no sample is offered
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            wait_ff      <= 4'h0;
            raw_valid_o  <= 1'b0;
            raw_sample_o <= 16'h0000;
        end else begin
            raw_valid_o  <= (wait_ff == 4'h1);
            raw_sample_o <= (wait_ff == 4'h1) ? level_i : ~raw_sample_o;
            if (conv_start_i) wait_ff <= slow_i ? 4'h6 : 4'h2;
            else if (wait_ff != 4'h0) wait_ff <= wait_ff - 4'h1;
        end
    end
endmodule

// >>> sim/adc_sample_correction_acquisition_test.sv
// self-checking bench for the sample acquisition block
`timescale 1ns/1ps
module adc_sample_correction_acquisition_test
    import acq_pkg::*;
;
    logic        clk_i = 1'b0, rst_i = 1'b1, reg_wr_i = 1'b0, reg_rd_i = 1'b0, slow = 1'b0;
    logic [15:0] reg_addr_i = 16'h0000, level = 16'h1000, raw_sample_i;
    logic [31:0] reg_wdata_i = 32'h0000_0000, reg_rdata_o;
    logic        irq_o, conv_start_o, raw_valid_i;
    logic [2:0]  conv_chan_o;
    logic [3:0]  conv_range_o;
    int          error_cnt = 0, comparisons = 0;
    always #50 clk_i = ~clk_i;
    adc_sample_correction_acquisition dut_u (.clk_i, .rst_i, .reg_wr_i, .reg_rd_i, .reg_addr_i,
        .reg_wdata_i, .reg_rdata_o, .irq_o, .conv_start_o, .conv_chan_o, .conv_range_o,
        .raw_valid_i, .raw_sample_i);
    adc_converter_model adc_u (.clk_i, .rst_i, .conv_start_i(conv_start_o), .slow_i(slow),
        .level_i(level), .raw_valid_o(raw_valid_i), .raw_sample_o(raw_sample_i));
    task automatic end_of_test();
        $display("comparisons %0d errors %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wr(input logic [15:0] a, input logic [31:0] d);
        @(posedge clk_i);
        reg_wr_i    <= 1'b1;
        reg_addr_i  <= a;
        reg_wdata_i <= d;
        @(posedge clk_i);
        reg_wr_i <= 1'b0;
    endtask
    task automatic rd(input logic [15:0] a, output logic [31:0] d);
        @(posedge clk_i);
        reg_rd_i   <= 1'b1;
        reg_addr_i <= a;
        @(posedge clk_i);
        reg_rd_i <= 1'b0;
        #1;
        d = reg_rdata_o;
    endtask
    task automatic t_reset();
        logic [15:0] regs [5] = '{CONV_TIMER_ADDR, FIFO_THRESH_ADDR, RANGE_CHAN_ADDR,
                                  ACQ_CONTROL_ADDR, 16'h0000};
        logic [31:0] d;
        foreach (regs[i]) begin
            rd(regs[i], d);
            chk("reset readback", 32'h0000_0000, d);
        end
    endtask
    task automatic t_run();
        int          gap;
        logic [31:0] d;
        wr(COEF_BASE_ADDR + 16'h0030, 32'h0000_0100);
        wr(COEF_BASE_ADDR + 16'h0034, 32'h0001_8000);
        wr(IRQ_ENABLE_ADDR, 32'h0000_0200);
        wr(ACQ_CONTROL_ADDR, 32'h0000_0002);
        wr(RANGE_CHAN_ADDR, 32'h0000_0007);
        wr(CONV_TIMER_ADDR, 32'h0000_0053);
        wr(FIFO_THRESH_ADDR, 32'h0000_03c0);
        wr(CONV_START_ADDR, 32'h0000_0001);
        for (int i = 0; i < 40 && conv_start_o !== 1'b1; i++) @(negedge clk_i);
        @(negedge clk_i);
        for (gap = 1; gap < 40 && conv_start_o !== 1'b1; gap++) @(negedge clk_i);
        chk("interval", 32'h1, 32'(gap == 13 || gap == 14));
        for (int i = 0; i < 16000 && irq_o !== 1'b1; i++) @(negedge clk_i);
        chk("irq_o", 32'h1, 32'(irq_o));
        if (irq_o !== 1'b1) end_of_test();
        rd(FIFO_COUNT_ADDR, d);
        chk("threshold count", 32'h1, 32'(d >= 960 && d <= 961));
        for (int i = 0; i < 50 && d !== 32'd1024; i++) begin
            repeat (100) @(posedge clk_i);
            rd(FIFO_COUNT_ADDR, d);
        end
        chk("full count", 32'd1024, d);
        wr(IRQ_ENABLE_ADDR, 32'h0000_0000);
        repeat (2) @(negedge clk_i);
        chk("masked irq_o", 32'h0, 32'(irq_o));
        wr(ACQ_CONTROL_ADDR, 32'h0000_0000);
        for (int i = 0; i < 1100; i++) begin
            rd(FIFO_DATA_ADDR, d);
            if (d === 32'h0000_0000) break;
            chk("corrected sample", 32'h0000_1980, d);
        end
        repeat (60) @(posedge clk_i);
        rd(FIFO_COUNT_ADDR, d);
        chk("count after stop", 32'h0, d);
        rd(CONV_TIMER_ADDR, d);
        chk("timer kept", 32'h0000_0053, d);
    endtask
    task automatic t_single();
        logic [15:0] lv [3] = '{16'h1000, 16'hf000, 16'h8100};
        logic [31:0] ex [3] = '{32'h0000_8000, 32'h0000_7fff, 32'h0000_0400};
        logic [31:0] d;
        slow <= 1'b1;
        wr(RANGE_CHAN_ADDR, 32'h0000_0001);
        wr(COEF_BASE_ADDR + 16'h0004, 32'h0004_0000);
        foreach (lv[i]) begin
            level <= lv[i];
            wr(CONV_START_ADDR, 32'h0000_0001);
            d = 32'h0;
            for (int k = 0; k < 40 && d !== 32'h1; k++) rd(FIFO_COUNT_ADDR, d);
            rd(FIFO_DATA_ADDR, d);
            chk("unipolar sample", ex[i], d);
        end
        chk("conv_chan_o", 32'h0, 32'(conv_chan_o));
        chk("conv_range_o", 32'h1, 32'(conv_range_o));
        repeat (40) @(posedge clk_i);
        rd(FIFO_COUNT_ADDR, d);
        chk("one shot count", 32'h0, d);
    endtask
    initial begin
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
        t_reset();
        t_run();
        t_single();
        end_of_test();
    end
endmodule
